//--- verilog/hdr_check_consts.vh
// Operation
// - crc-8 over four header bytes, x8+x2+x+1
// - coset option xors 0x55 into inserted byte
// - control 0 bit 6 enables header verification
// - mismatch raises interrupt, active-low pin low
// - mismatch sets status bit 1, read clears
// - mismatch increments 32-bit tally, read clears
// - tally as four bytes, msb lowest address
// - tally saturates at all ones until read
// - erred headers never corrected, passed or dropped
// - erred cell discarded unless recompute enabled
// - recompute inserts fresh byte while verification is on, no discards
// - invert bit flips inserted byte when recomputing
// - verification off passes all cells silently
`ifndef HDR_CHECK_CONSTS_VH
`define HDR_CHECK_CONSTS_VH

// register offsets on the microprocessor port
`define OFS_CTRL_LOW 8'h03
`define OFS_CTRL_HIGH 8'h02
`define OFS_IRQ_STATUS 8'h0B
`define OFS_TALLY_B3 8'h30
`define OFS_TALLY_B2 8'h31
`define OFS_TALLY_B1 8'h32
`define OFS_TALLY_B0 8'h33

// field positions
`define BIT_HEC_INVERT 7
`define BIT_CHECK_EN 6
`define BIT_RECALC_EN 0
`define BIT_COSET_EN 1
`define BIT_HDR_ERR_STAT 1

// writable masks and reset values
`define CTRL_LOW_WMASK 8'hF9
`define CTRL_LOW_RST 8'h00
`define CTRL_HIGH_RST 8'h00
`define TALLY_RST 32'h00000000
`define TALLY_MAX 32'hFFFFFFFF

// code constants
`define CRC_POLY 8'h07
`define COSET_MASK 8'h55
`define INVERT_MASK 8'hFF

// cell geometry
`define CELL_LEN 6'h35
`define HDR_LEN 6'h04
`define HEC_POS 6'h04

`endif

//--- verilog/cell_fifo.v
`timescale 1ns/1ns
// small fifo with a registered output stage
module cell_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // filling side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // draining side
   output reg out_valid_r,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data_r
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
   reg [AW-1:0] wr_ptr_r; // write index
   reg [AW-1:0] rd_ptr_r; // read index
   reg [AW:0] cnt_r; // words held in storage
   wire in_fire;
   wire load;
   wire mem_empty;
   wire bypass;
   wire pop;
   wire push;

   // honest full: storage only, output stage counts extra
   assign in_ready = (cnt_r < DEPTH);
   assign in_fire = in_valid & in_ready;
   assign load = ~out_valid_r | out_ready;
   assign mem_empty = (cnt_r == {(AW+1){1'b0}});
   // an empty store lets a word skip straight to the output
   assign bypass = load & mem_empty & in_fire;
   assign pop = load & ~mem_empty;
   assign push = in_fire & ~bypass;

   // storage write
   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // pointers, count and output stage
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         out_valid_r <= 1'b0;
         out_data_r <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
            out_data_r <= mem[rd_ptr_r];
         end else if (bypass) begin
            out_data_r <= in_data;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
         if (load) begin
            out_valid_r <= pop | bypass;
         end
      end
   end
endmodule

//--- verilog/hdr_check_insert.v
`timescale 1ns/1ns
`include "hdr_check_consts.vh"
// header check, tally and insertion stage of the transmit cell path
module hdr_check_insert #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // microprocessor port
   input wire [7:0] up_addr,
   input wire up_wr,
   input wire up_rd,
   input wire [7:0] up_wdata,
   output reg [7:0] up_rdata_r,
   // interrupt pin, active low
   output wire irq_n,
   // cells from idle generator and user filter
   input wire cell_in_valid,
   output reg cell_in_ready,
   input wire [7:0] cell_in_data,
   input wire cell_in_soc,
   // cells toward the transmit data path
   output wire cell_out_valid,
   input wire cell_out_ready,
   output wire [7:0] cell_out_data,
   output wire cell_out_soc
);
   localparam ST_HDR = 2'b00; // collecting five header bytes
   localparam ST_EMIT = 2'b01; // pushing header into fifo
   localparam ST_PAY = 2'b10; // passing or dropping payload

   // one byte step of the serial crc
   function [7:0] crc8_step;
      input [7:0] crc;
      input [7:0] din;
      reg [7:0] c;
      integer i;
      begin
         c = crc ^ din;
         for (i = 0; i < 8; i = i + 1) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
         end
         crc8_step = c;
      end
   endfunction

   reg [7:0] ctrl_low_r; // control byte 0
   reg [7:0] ctrl_high_r; // control byte 1
   reg hdr_err_stat_r; // sticky header error status
   reg [31:0] tally_r; // live error tally
   reg [31:0] snap_r; // tally copy taken when msb byte is read
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [5:0] idx_r; // byte index within cell
   reg [7:0] crc_r; // running crc of header bytes
   reg [7:0] hdr0_r;
   reg [7:0] hdr1_r;
   reg [7:0] hdr2_r;
   reg [7:0] hdr3_r;
   reg [7:0] hec_r; // byte to send in fifth octet
   reg drop_r; // current cell is being discarded
   reg [2:0] emit_r; // header byte being emitted
   reg fifo_in_valid;
   reg [8:0] fifo_in_data;
   wire fifo_in_ready;
   wire [8:0] fifo_out_data;
   wire in_fire;
   wire check_en;
   wire recalc_on;
   wire [7:0] coset_term;
   wire [7:0] expect_hec;
   wire [7:0] insert_hec;
   wire hec_arrive;
   wire hdr_err;
   wire rd_stat;
   wire rd_tally_msb;

   assign check_en = ctrl_low_r[`BIT_CHECK_EN];
   // recompute bit means nothing while checking is off
   assign recalc_on = check_en & ctrl_high_r[`BIT_RECALC_EN];
   // coset only lands on a recomputed byte
   assign coset_term = (recalc_on & ctrl_high_r[`BIT_COSET_EN]) ?
      `COSET_MASK : 8'h00;
   assign expect_hec = crc_r ^ (ctrl_high_r[`BIT_COSET_EN] ?
      `COSET_MASK : 8'h00);
   assign insert_hec = crc_r ^ coset_term ^
      (ctrl_low_r[`BIT_HEC_INVERT] ? `INVERT_MASK : 8'h00);
   assign in_fire = cell_in_valid & cell_in_ready;
   assign hec_arrive = in_fire & (state_r == ST_HDR) &
      ~cell_in_soc & (idx_r == `HEC_POS);
   // mismatch only counts while checking is on
   assign hdr_err = hec_arrive & check_en &
      (cell_in_data != expect_hec);
   assign rd_stat = up_rd & (up_addr == `OFS_IRQ_STATUS);
   assign rd_tally_msb = up_rd & (up_addr == `OFS_TALLY_B3);
   assign irq_n = ~hdr_err_stat_r;

   // control registers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_low_r <= `CTRL_LOW_RST;
         ctrl_high_r <= `CTRL_HIGH_RST;
      end else if (up_wr) begin
         if (up_addr == `OFS_CTRL_LOW) begin
            // bits 2 and 1 are read-only zero
            ctrl_low_r <= up_wdata & `CTRL_LOW_WMASK;
         end
         if (up_addr == `OFS_CTRL_HIGH) begin
            ctrl_high_r <= up_wdata;
         end
      end
   end

   // sticky status, a new error beats the clearing read
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         hdr_err_stat_r <= 1'b0;
      end else if (hdr_err) begin
         hdr_err_stat_r <= 1'b1;
      end else if (rd_stat) begin
         hdr_err_stat_r <= 1'b0;
      end
   end

   // saturating tally, cleared by reading its top byte
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tally_r <= `TALLY_RST;
         snap_r <= `TALLY_RST;
      end else begin
         if (rd_tally_msb) begin
            // copy keeps the four bytes coherent across reads
            snap_r <= tally_r;
            tally_r <= hdr_err ? 32'h00000001 : `TALLY_RST;
         end else if (hdr_err & (tally_r != `TALLY_MAX)) begin
            tally_r <= tally_r + 32'h00000001;
         end
      end
   end

   // read data, registered one cycle after the strobe
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         up_rdata_r <= 8'h00;
      end else if (up_rd) begin
         case (up_addr)
            `OFS_CTRL_LOW: up_rdata_r <= ctrl_low_r;
            `OFS_CTRL_HIGH: up_rdata_r <= ctrl_high_r;
            `OFS_IRQ_STATUS: begin
               up_rdata_r <= {6'h00, hdr_err_stat_r, 1'b0};
            end
            `OFS_TALLY_B3: up_rdata_r <= tally_r[31:24];
            `OFS_TALLY_B2: up_rdata_r <= snap_r[23:16];
            `OFS_TALLY_B1: up_rdata_r <= snap_r[15:8];
            `OFS_TALLY_B0: up_rdata_r <= snap_r[7:0];
            default: up_rdata_r <= 8'h00;
         endcase
      end
   end

   // next state and stream handshake
   always @* begin
      state_nxt = state_r;
      cell_in_ready = 1'b0;
      fifo_in_valid = 1'b0;
      fifo_in_data = 9'h000;
      case (state_r)
         ST_HDR: begin
            // header bytes are held locally, so never stall here
            cell_in_ready = 1'b1;
            if (hec_arrive) begin
               // drop skips emission and swallows the payload
               state_nxt = (hdr_err & ~recalc_on) ? ST_PAY : ST_EMIT;
            end
         end
         ST_EMIT: begin
            fifo_in_valid = 1'b1;
            case (emit_r)
               3'd0: fifo_in_data = {1'b1, hdr0_r};
               3'd1: fifo_in_data = {1'b0, hdr1_r};
               3'd2: fifo_in_data = {1'b0, hdr2_r};
               3'd3: fifo_in_data = {1'b0, hdr3_r};
               default: fifo_in_data = {1'b0, hec_r};
            endcase
            if (fifo_in_ready & (emit_r == 3'd4)) begin
               state_nxt = ST_PAY;
            end
         end
         ST_PAY: begin
            // a dropped cell drains at full rate
            cell_in_ready = drop_r | fifo_in_ready;
            fifo_in_valid = ~drop_r & cell_in_valid;
            fifo_in_data = {1'b0, cell_in_data};
            if (in_fire & (idx_r == `CELL_LEN - 6'h01)) begin
               state_nxt = ST_HDR;
            end
         end
         default: state_nxt = ST_HDR;
      endcase
   end

   // cell sequencing and header capture
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_HDR;
         idx_r <= 6'h00;
         crc_r <= 8'h00;
         hdr0_r <= 8'h00;
         hdr1_r <= 8'h00;
         hdr2_r <= 8'h00;
         hdr3_r <= 8'h00;
         hec_r <= 8'h00;
         drop_r <= 1'b0;
         emit_r <= 3'd0;
      end else begin
         state_r <= state_nxt;
         if ((state_r == ST_HDR) & in_fire) begin
            if (cell_in_soc) begin
               // start flag always realigns to byte 0
               hdr0_r <= cell_in_data;
               crc_r <= crc8_step(8'h00, cell_in_data);
               idx_r <= 6'h01;
            end else if (idx_r < `HDR_LEN) begin
               if (idx_r == 6'h01) hdr1_r <= cell_in_data;
               if (idx_r == 6'h02) hdr2_r <= cell_in_data;
               if (idx_r == 6'h03) hdr3_r <= cell_in_data;
               if (idx_r != 6'h00) begin
                  crc_r <= crc8_step(crc_r, cell_in_data);
                  idx_r <= idx_r + 6'h01;
               end
            end else begin
               // received byte kept unless recomputing
               hec_r <= recalc_on ? insert_hec : cell_in_data;
               drop_r <= hdr_err & ~recalc_on;
               emit_r <= 3'd0;
               idx_r <= idx_r + 6'h01;
            end
         end
         if ((state_r == ST_EMIT) & fifo_in_ready) begin
            emit_r <= emit_r + 3'd1;
         end
         if ((state_r == ST_PAY) & in_fire) begin
            idx_r <= (idx_r == `CELL_LEN - 6'h01) ? 6'h00 :
               idx_r + 6'h01;
         end
      end
   end

   // output buffer, its ready stalls the payload path
   cell_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_out_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid_r(cell_out_valid),
      .out_ready(cell_out_ready),
      .out_data_r(fifo_out_data)
   );

   assign cell_out_data = fifo_out_data[7:0];
   assign cell_out_soc = fifo_out_data[8];
endmodule

//--- tb/hdr_check_props.sv
`timescale 1ns/1ns
// watches the register port, interrupt pin and both cell streams
module hdr_check_props (
   // clock and reset
   input wire mclk,
   input wire rst,
   // microprocessor port and interrupt
   input wire [7:0] up_addr,
   input wire up_wr,
   input wire up_rd,
   input wire [7:0] up_wdata,
   input wire [7:0] up_rdata_r,
   input wire irq_n,
   // cell streams
   input wire cell_in_valid,
   input wire cell_in_ready,
   input wire [7:0] cell_in_data,
   input wire cell_in_soc,
   input wire cell_out_valid,
   input wire cell_out_ready,
   input wire [7:0] cell_out_data,
   input wire cell_out_soc
);
   reg chk_en_r; // shadow of the verification enable
   wire acc = cell_in_valid && cell_in_ready; // byte taken
   wire rd_st = up_rd && up_addr == 8'h0B; // status read
   wire rd_t3 = up_rd && up_addr == 8'h30; // tally top byte read
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // mirror control writes; takes effect a cycle later, as in the block
   always @(posedge mclk or posedge rst) begin
      if (rst) chk_en_r <= 1'b0;
      else if (up_wr && up_addr == 8'h03) chk_en_r <= up_wdata[6];
   end
   a_stat_read_shows: assert property (rd_st |=>
      up_rdata_r[1] == !$past(irq_n)) else $error("status bit not pin");
   a_irq_held_set: assert property (!irq_n && !rd_st |=> !irq_n)
      else $error("interrupt released without a read");
   a_irq_clear_read: assert property ($rose(irq_n) |-> $past(rd_st))
      else $error("interrupt released with no status read");
   a_irq_needs_check: assert property ($fell(irq_n) |->
      $past(chk_en_r && acc)) else $error("interrupt not from a check");
   a_quiet_when_off: assert property (!chk_en_r && irq_n |=> irq_n)
      else $error("interrupt while verification off");
   a_out_stands: assert property (cell_out_valid && !cell_out_ready |=>
      cell_out_valid && $stable(cell_out_data) && $stable(cell_out_soc))
      else $error("output byte changed while refused");
   a_tally_read_clear: assert property (rd_t3 && !acc ##1 !acc
      ##1 rd_t3 && !acc |=> up_rdata_r == 8'h00)
      else $error("tally not cleared by read");
   a_ctrl_readback: assert property (up_wr && up_addr == 8'h03 ##1
      !up_wr ##1 up_rd && !up_wr && up_addr == 8'h03 |=>
      up_rdata_r == ($past(up_wdata, 3) & 8'hF9))
      else $error("control byte readback wrong");
   cover property ($fell(irq_n));
   cover property (cell_out_valid && cell_out_ready && cell_out_soc);
   cover property (cell_in_valid && !cell_in_ready);
endmodule

//--- tb/cell_src.sv
`timescale 1ns/1ns
// upstream cell source: one 53-byte cell per start pulse
module cell_src (
   // clock and reset
   input wire mclk,
   input wire rst,
   // bench control
   input wire start,
   input wire [39:0] hdr,
   output wire busy,
   // cell stream toward the block
   output reg cell_in_valid,
   input wire cell_in_ready,
   output reg [7:0] cell_in_data,
   output reg cell_in_soc
);
   reg [5:0] k_r; // byte index within the cell
   assign busy = cell_in_valid;
   // header and check byte first, then payload equal to its index
   function [7:0] at(input [5:0] k);
      at = k < 6'h05 ? hdr[39-8*k -: 8] : {2'b00, k};
   endfunction
   // hold each byte until taken; idle data is the inverse of the last
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cell_in_valid <= 1'b0;
         cell_in_data <= 8'h00;
         cell_in_soc <= 1'b0;
         k_r <= 6'h00;
      end else if (cell_in_valid && cell_in_ready) begin
         cell_in_soc <= 1'b0;
         k_r <= k_r + 6'h01;
         cell_in_data <= k_r == 6'h34 ? ~cell_in_data : at(k_r + 6'h01);
         cell_in_valid <= k_r != 6'h34;
      end else if (start && !cell_in_valid) begin
         cell_in_valid <= 1'b1;
         cell_in_soc <= 1'b1;
         cell_in_data <= hdr[39:32];
         k_r <= 6'h00;
      end
   end
endmodule

//--- tb/tb_hdr_check_insert.sv
`timescale 1ns/1ns
module tb_hdr_check_insert;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] up_addr = 8'h00;
   reg up_wr = 1'b0;
   reg up_rd = 1'b0;
   reg [7:0] up_wdata = 8'h00;
   reg cell_out_ready = 1'b0;
   reg start = 1'b0; // launch one cell
   reg hold_out = 1'b0; // far side refuses all bytes
   reg [39:0] hdr = 40'h0;
   wire [7:0] up_rdata_r, cell_in_data, cell_out_data;
   wire irq_n, cell_in_valid, cell_in_ready, cell_in_soc, busy;
   wire cell_out_valid, cell_out_soc;
   reg [7:0] ob [0:63]; // last cell seen at the output
   reg [7:0] v, crc, hec, xh, lo, hi;
   reg err, pass;
   integer pos = 0, tot = 0, cyc = 0, bad_count = 0, n_compared = 0;
   integer i, k, base, errs = 0;
   // control low/high per cell; coset only with recompute
   wire [127:0] modes = {16'h0000, 16'h4000, 16'h4000, 16'h4001,
      16'h4003, 16'hC001, 16'hC003, 16'h0001};
   hdr_check_insert dut (.mclk(mclk), .rst(rst), .up_addr(up_addr),
      .up_wr(up_wr), .up_rd(up_rd), .up_wdata(up_wdata),
      .up_rdata_r(up_rdata_r), .irq_n(irq_n),
      .cell_in_valid(cell_in_valid), .cell_in_ready(cell_in_ready),
      .cell_in_data(cell_in_data), .cell_in_soc(cell_in_soc),
      .cell_out_valid(cell_out_valid), .cell_out_ready(cell_out_ready),
      .cell_out_data(cell_out_data), .cell_out_soc(cell_out_soc));
   cell_src src (.mclk(mclk), .rst(rst), .start(start), .hdr(hdr),
      .busy(busy), .cell_in_valid(cell_in_valid),
      .cell_in_ready(cell_in_ready), .cell_in_data(cell_in_data),
      .cell_in_soc(cell_in_soc));
   always #10 mclk = ~mclk;
   // reference crc, msb first, zero start
   function [7:0] crc8(input [31:0] d);
      integer b;
      reg [7:0] c;
      begin
         c = 8'h00;
         for (b = 31; b >= 0; b = b - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? 8'h07 : 8'h00);
         crc8 = c;
      end
   endfunction
   // output side stalls one cycle in four; soc restarts capture
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      cell_out_ready <= !hold_out && cyc % 4 != 3;
      if (cell_out_valid && cell_out_ready) begin
         ob[cell_out_soc ? 0 : pos] <= cell_out_data;
         pos <= cell_out_soc ? 1 : pos + 1;
         tot <= tot + 1;
      end
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk);
         up_wr <= 1'b1;
         up_addr <= a;
         up_wdata <= d;
         @(posedge mclk);
         up_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge mclk);
         up_rd <= 1'b1;
         up_addr <= a;
         @(posedge mclk);
         up_rd <= 1'b0;
         #1 d = up_rdata_r;
      end
   endtask
   task close_out;
      begin
         $display("compared %0d mismatched %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h03, v); check(v, 8'h00);
      rd(8'h55, v); check(v, 8'h00);
      check(irq_n, 1'b1);
      wr(8'h03, 8'hFF);
      rd(8'h03, v); check(v, 8'hF9);
      $display("test registers done");
      for (i = 0; i < 8; i = i + 1) begin
         {lo, hi} = modes[127-16*i -: 16];
         crc = crc8(32'hA1234567);
         hec = i == 1 ? crc : crc ^ 8'h80; // only cell 1 is clean
         err = lo[6] && i != 1;
         pass = !(err && !hi[0]);
         xh = crc ^ (hi[1] ? 8'h55 : 8'h00) ^ (lo[7] ? 8'hFF : 8'h00);
         xh = lo[6] && hi[0] ? xh : hec;
         errs = errs + err;
         wr(8'h03, lo);
         wr(8'h02, hi);
         hdr = {32'hA1234567, hec};
         base = tot;
         @(posedge mclk);
         start <= 1'b1;
         hold_out <= i == 1;
         @(posedge mclk);
         start <= 1'b0;
         if (i == 1) begin
            repeat (40) @(posedge mclk);
            #1 check(cell_in_ready, 1'b0); check(tot - base, 0);
            @(posedge mclk);
            hold_out <= 1'b0;
         end
         k = 0;
         // step off the edge so busy is seen after the source has moved
         #1;
         while (k < 300 && (busy !== 1'b0 || tot - base < 53 * pass)) begin
            @(posedge mclk);
            #1 k = k + 1;
         end
         repeat (8) @(posedge mclk);
         #1 check(tot - base, 53 * pass);
         if (pass) begin
            check(ob[0], 8'hA1);
            check(ob[4], xh);
            check(ob[52], 8'h34);
         end
         check(irq_n, !err);
         rd(8'h0B, v); check(v[1], err);
         check(irq_n, 1'b1);
         $display("test cell %0d done", i);
      end
      rd(8'h30, v); check(v, 8'h00);
      rd(8'h31, v); check(v, 8'h00);
      rd(8'h32, v); check(v, 8'h00);
      rd(8'h33, v); check(v, errs);
      rd(8'h30, v); check(v, 8'h00);
      rd(8'h30, v); check(v, 8'h00);
      rd(8'h33, v); check(v, 8'h00);
      $display("test tally done");
      close_out;
   end
endmodule
bind hdr_check_insert hdr_check_props props (.mclk(mclk), .rst(rst),
   .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd), .up_wdata(up_wdata),
   .up_rdata_r(up_rdata_r), .irq_n(irq_n), .cell_in_valid(cell_in_valid),
   .cell_in_ready(cell_in_ready), .cell_in_data(cell_in_data),
   .cell_in_soc(cell_in_soc), .cell_out_valid(cell_out_valid),
   .cell_out_ready(cell_out_ready), .cell_out_data(cell_out_data),
   .cell_out_soc(cell_out_soc));
